// ===== etp_pkg.sv
// How it works
// - Conversion A period: 00 off, else 1-3 events
// - Conversion A pulse only while its enable is set
// - Conversion A flag never suppresses the pulse
// - Conversion A count clears when pulse issues
// - Readable 2-bit interrupt event count, 0 to 3
// - Interrupt count clears when interrupt fires
// - Disabled or flagged: count stops at period
// - Interrupt period: 00 off, force ignored
// - Interrupt pulse only while interrupt enabled
// - Set flag withholds interrupts until software clears
// - Saturated count keeps one interrupt pending
// - Writing period equal to count fires interrupt
// - Event during period write still counts
// - Readable 2-bit conversion A count, 0 to 3
// - Conversion A pulse sets its latched flag
// - Interrupt pulse sets its latched flag
package etp_pkg;
	// Width of the register bus byte address.
	localparam int ADDR_W = 8;
	// Width of the register bus data.
	localparam int DATA_W = 32;
	// Byte addresses of the registers.
	localparam logic [7:0] OFF_PRESCALE = 8'h00;
	localparam logic [7:0] OFF_CONTROL  = 8'h04;
	localparam logic [7:0] OFF_FLAG     = 8'h08;
	localparam logic [7:0] OFF_CLEAR    = 8'h0c;
	localparam logic [7:0] OFF_FORCE    = 8'h10;
	// Field positions inside the prescale register.
	localparam int IRQ_PRD_LSB   = 0;
	localparam int IRQ_CNT_LSB   = 2;
	localparam int CONVA_PRD_LSB = 8;
	localparam int CONVA_CNT_LSB = 10;
	// Bit positions inside the control register.
	localparam int CTRL_IRQ_EN_BIT   = 0;
	localparam int CTRL_CONVA_EN_BIT = 1;
	// Bit positions shared by the flag, clear and force registers.
	localparam int FLAG_IRQ_BIT   = 0;
	localparam int FLAG_CONVA_BIT = 2;
	// Two-bit period and count values.
	typedef logic [1:0] count2_t;
	localparam count2_t PERIOD_OFF  = 2'h0;
	localparam count2_t COUNT_RESET = 2'h0;
	localparam count2_t COUNT_MAX   = 2'h3;
	localparam count2_t PRD_RESET   = 2'h0;
	// Reset value of enable and flag bits.
	localparam logic BIT_RESET = 1'b0;
	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== axil_slave_port.sv
`timescale 1ns/10ps
// Bus slave handshake: takes address and data in either order, one write and one read at once.
module axil_slave_port
	import etp_pkg::*;
(
	input  wire logic              clk_in,       // System clock.
	input  wire logic              rst_in,       // Synchronous reset, active high.
	input  wire logic [ADDR_W-1:0] awaddr_in,    // Write address.
	input  wire logic              awvalid_in,   // Write address valid.
	output logic                   awready_out,  // Write address ready.
	input  wire logic [DATA_W-1:0] wdata_in,     // Write data.
	input  wire logic [3:0]        wstrb_in,     // Write byte strobes.
	input  wire logic              wvalid_in,    // Write data valid.
	output logic                   wready_out,   // Write data ready.
	output logic [1:0]             bresp_out,    // Write response.
	output logic                   bvalid_out,   // Write response valid.
	input  wire logic              bready_in,    // Write response ready.
	input  wire logic [ADDR_W-1:0] araddr_in,    // Read address.
	input  wire logic              arvalid_in,   // Read address valid.
	output logic                   arready_out,  // Read address ready.
	output logic [DATA_W-1:0]      rdata_out,    // Read data.
	output logic [1:0]             rresp_out,    // Read response.
	output logic                   rvalid_out,   // Read data valid.
	input  wire logic              rready_in,    // Read data ready.
	output logic                   wr_pulse_out, // One-cycle write strobe to the registers.
	output logic [ADDR_W-1:0]      wr_addr_out,  // Held write address.
	output logic [DATA_W-1:0]      wr_data_out,  // Held write data.
	output logic [3:0]             wr_strb_out,  // Held byte strobes.
	input  wire logic              wr_ok_in,     // The write address is mapped.
	output logic [ADDR_W-1:0]      rd_addr_out,  // Held read address.
	input  wire logic [DATA_W-1:0] rd_data_in,   // Read word for the held address.
	input  wire logic              rd_ok_in      // The read address is mapped.
);
	logic aw_held; // Write address taken and waiting.
	logic w_held;  // Write data taken and waiting.
	logic ar_held; // Read address taken and waiting.

	// Handshakes that complete in this cycle.
	wire aw_take  = awvalid_in && awready_out;
	wire w_take   = wvalid_in && wready_out;
	wire ar_take  = arvalid_in && arready_out;
	wire both_in  = aw_held && w_held && !bvalid_out && !wr_pulse_out;

	// Write side: capture each channel, then issue one strobe and the response.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			awready_out  <= 1'b0;
			wready_out   <= 1'b0;
			bvalid_out   <= 1'b0;
			bresp_out    <= RESP_OKAY;
			wr_pulse_out <= 1'b0;
			wr_addr_out  <= '0;
			wr_data_out  <= '0;
			wr_strb_out  <= 4'h0;
		end
		else
		begin
			// Ready is offered only while the channel has nothing held.
			awready_out  <= !aw_held && !aw_take;
			wready_out   <= !w_held && !w_take;
			wr_pulse_out <= both_in;
			if (aw_take)
			begin
				aw_held     <= 1'b1;
				wr_addr_out <= awaddr_in;
			end
			if (w_take)
			begin
				w_held      <= 1'b1;
				wr_data_out <= wdata_in;
				wr_strb_out <= wstrb_in;
			end
			// The strobe cycle also raises the response.
			if (wr_pulse_out)
			begin
				bvalid_out <= 1'b1;
				bresp_out  <= wr_ok_in ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_out && bready_in)
			begin
				// Response taken: both channels may be offered again.
				bvalid_out  <= 1'b0;
				aw_held     <= 1'b0;
				w_held      <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	// Read side: hold the address one cycle, then present the registered word.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ar_held     <= 1'b0;
			arready_out <= 1'b0;
			rvalid_out  <= 1'b0;
			rdata_out   <= '0;
			rresp_out   <= RESP_OKAY;
			rd_addr_out <= '0;
		end
		else
		begin
			arready_out <= !ar_held && !ar_take && !rvalid_out;
			if (ar_take)
			begin
				ar_held     <= 1'b1;
				rd_addr_out <= araddr_in;
			end
			else if (ar_held && !rvalid_out)
			begin
				// Unmapped reads answer zero with an error.
				rvalid_out <= 1'b1;
				rdata_out  <= rd_ok_in ? rd_data_in : '0;
				rresp_out  <= rd_ok_in ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_out && rready_in)
			begin
				rvalid_out  <= 1'b0;
				ar_held     <= 1'b0;
				arready_out <= 1'b1;
			end
		end
	end
endmodule

// ===== event_trigger_prescaler.sv
`timescale 1ns/10ps
// Event prescaler: counts timer events and issues an interrupt pulse and a conversion A pulse.
module event_trigger_prescaler
	import etp_pkg::*;
(
	input  wire logic                       CLK_SYS_IN,            // System clock, 40 MHz.
	input  wire logic                       SYS_RST_IN,            // Synchronous reset, high.
	input  wire logic [etp_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,       // Write address.
	input  wire logic                       S_AXI_AWVALID_IN,      // Write address valid.
	output logic                            S_AXI_AWREADY_OUT,     // Write address ready.
	input  wire logic [etp_pkg::DATA_W-1:0] S_AXI_WDATA_IN,        // Write data.
	input  wire logic [3:0]                 S_AXI_WSTRB_IN,        // Write byte strobes.
	input  wire logic                       S_AXI_WVALID_IN,       // Write data valid.
	output logic                            S_AXI_WREADY_OUT,      // Write data ready.
	output logic [1:0]                      S_AXI_BRESP_OUT,       // Write response.
	output logic                            S_AXI_BVALID_OUT,      // Write response valid.
	input  wire logic                       S_AXI_BREADY_IN,       // Write response ready.
	input  wire logic [etp_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,       // Read address.
	input  wire logic                       S_AXI_ARVALID_IN,      // Read address valid.
	output logic                            S_AXI_ARREADY_OUT,     // Read address ready.
	output logic [etp_pkg::DATA_W-1:0]      S_AXI_RDATA_OUT,       // Read data.
	output logic [1:0]                      S_AXI_RRESP_OUT,       // Read response.
	output logic                            S_AXI_RVALID_OUT,      // Read data valid.
	input  wire logic                       S_AXI_RREADY_IN,       // Read data ready.
	input  wire logic                       IRQ_EVENT_IN,          // Selected interrupt event.
	input  wire logic                       CONVA_EVENT_IN,        // Selected conversion A event.
	output logic                            PWM_IRQ_PULSE_OUT,     // Interrupt pulse.
	output logic                            CONVSTART_A_PULSE_OUT  // Conversion A start pulse.
);
	count2_t irq_period;    // Programmed interrupt period select.
	count2_t irq_count;     // Interrupt event count.
	count2_t conva_period;  // Programmed conversion A period select.
	count2_t conva_count;   // Conversion A event count.
	logic    irq_enable;    // Interrupt enable.
	logic    conva_enable;  // Conversion A enable.
	logic    irq_flag;      // Latched interrupt flag.
	logic    conva_flag;    // Latched conversion A flag.

	logic                wr_pulse; // One-cycle register write strobe.
	logic [ADDR_W-1:0]   wr_addr;  // Address of the write.
	logic [DATA_W-1:0]   wr_data;  // Data of the write.
	logic [3:0]          wr_strb;  // Byte strobes of the write.
	logic [ADDR_W-1:0]   rd_addr;  // Address of the pending read.
	logic [DATA_W-1:0]   rd_word;  // Word for the pending read.
	logic                wr_mapped; // The write address hits a register.
	logic                rd_mapped; // The read address hits a register.

	// The bus slave owns all handshakes; this module only sees strobes.
	axil_slave_port u_port (
		.clk_in       (CLK_SYS_IN),
		.rst_in       (SYS_RST_IN),
		.awaddr_in    (S_AXI_AWADDR_IN),
		.awvalid_in   (S_AXI_AWVALID_IN),
		.awready_out  (S_AXI_AWREADY_OUT),
		.wdata_in     (S_AXI_WDATA_IN),
		.wstrb_in     (S_AXI_WSTRB_IN),
		.wvalid_in    (S_AXI_WVALID_IN),
		.wready_out   (S_AXI_WREADY_OUT),
		.bresp_out    (S_AXI_BRESP_OUT),
		.bvalid_out   (S_AXI_BVALID_OUT),
		.bready_in    (S_AXI_BREADY_IN),
		.araddr_in    (S_AXI_ARADDR_IN),
		.arvalid_in   (S_AXI_ARVALID_IN),
		.arready_out  (S_AXI_ARREADY_OUT),
		.rdata_out    (S_AXI_RDATA_OUT),
		.rresp_out    (S_AXI_RRESP_OUT),
		.rvalid_out   (S_AXI_RVALID_OUT),
		.rready_in    (S_AXI_RREADY_IN),
		.wr_pulse_out (wr_pulse),
		.wr_addr_out  (wr_addr),
		.wr_data_out  (wr_data),
		.wr_strb_out  (wr_strb),
		.wr_ok_in     (wr_mapped),
		.rd_addr_out  (rd_addr),
		.rd_data_in   (rd_word),
		.rd_ok_in     (rd_mapped)
	);

	// Word index of each access; the low two address bits are ignored.
	wire [5:0] wr_index = wr_addr[7:2];
	wire [5:0] rd_index = rd_addr[7:2];

	// Register selects on the write side.
	wire hit_prescale = (wr_index == OFF_PRESCALE[7:2]);
	wire hit_control  = (wr_index == OFF_CONTROL[7:2]);
	wire hit_flag     = (wr_index == OFF_FLAG[7:2]);
	wire hit_clear    = (wr_index == OFF_CLEAR[7:2]);
	wire hit_force    = (wr_index == OFF_FORCE[7:2]);
	assign wr_mapped  = hit_prescale || hit_control || hit_flag || hit_clear || hit_force;

	// Byte-lane qualified write strobes.
	wire wr_low_byte  = wr_pulse && wr_strb[0];
	wire wr_high_byte = wr_pulse && wr_strb[1];
	wire irq_prd_wr   = wr_low_byte && hit_prescale;
	wire conva_prd_wr = wr_high_byte && hit_prescale;
	wire ctrl_wr      = wr_low_byte && hit_control;

	// Write-one-to-clear and force requests; writing zero does nothing.
	wire clr_irq      = wr_low_byte && hit_clear && wr_data[FLAG_IRQ_BIT];
	wire clr_conva    = wr_low_byte && hit_clear && wr_data[FLAG_CONVA_BIT];
	wire frc_irq      = wr_low_byte && hit_force && wr_data[FLAG_IRQ_BIT];

	// Next values of the programmed fields.
	wire count2_t next_irq_period   = irq_prd_wr ? wr_data[IRQ_PRD_LSB+:2] : irq_period;
	wire count2_t next_conva_period = conva_prd_wr ? wr_data[CONVA_PRD_LSB+:2] : conva_period;
	wire next_irq_enable   = ctrl_wr ? wr_data[CTRL_IRQ_EN_BIT] : irq_enable;
	wire next_conva_enable = ctrl_wr ? wr_data[CTRL_CONVA_EN_BIT] : conva_enable;

	// Interrupt path. A period of zero turns the counter and force off.
	wire irq_counting = (irq_period != PERIOD_OFF);
	// Interrupts are blocked while disabled or while the flag is still set.
	wire irq_blocked  = !irq_enable || irq_flag;
	// Count has met the period; this also fires right after a period write equal to it.
	wire irq_reached  = (irq_count == irq_period);
	// Fire on reaching the period, or on a force request, only when not blocked.
	wire irq_fire     = irq_counting && !irq_blocked && (irq_reached || frc_irq);
	// A blocked counter parks at the period, which keeps one interrupt pending.
	wire irq_hold     = irq_blocked && irq_reached;
	// An event counts even in the cycle of a period write, whatever the new value.
	wire irq_step     = IRQ_EVENT_IN && (irq_counting || irq_prd_wr) && !irq_hold
		&& (irq_count != COUNT_MAX);

	// Next interrupt count: cleared by the interrupt, else stepped by an event.
	wire count2_t next_irq_count = irq_fire ? COUNT_RESET
		: count2_t'(irq_count + {1'b0, irq_step});

	// Interrupt flag: set by the interrupt, cleared by software; the set wins.
	wire next_irq_flag = irq_fire || (irq_flag && !clr_irq);

	// Conversion A path. A period of zero turns the counter off.
	wire conva_counting = (conva_period != PERIOD_OFF);
	wire conva_reached  = (conva_count == conva_period);
	// The flag plays no part here: an old flag never stops the pulse.
	wire conva_fire     = conva_counting && conva_enable && conva_reached;
	// While disabled the counter parks at the period instead of wrapping.
	wire conva_hold     = !conva_enable && conva_reached;
	wire conva_step     = CONVA_EVENT_IN && conva_counting && !conva_hold
		&& (conva_count != COUNT_MAX);

	// Next conversion A count: cleared together with the pulse.
	wire count2_t next_conva_count = conva_fire ? COUNT_RESET
		: count2_t'(conva_count + {1'b0, conva_step});

	// Conversion A flag: set by the pulse, cleared by software; the set wins.
	wire next_conva_flag = conva_fire || (conva_flag && !clr_conva);

	// Read selects and the read word, narrow fields in the low bits.
	wire rd_prescale = (rd_index == OFF_PRESCALE[7:2]);
	wire rd_control  = (rd_index == OFF_CONTROL[7:2]);
	wire rd_flag     = (rd_index == OFF_FLAG[7:2]);
	wire rd_clear    = (rd_index == OFF_CLEAR[7:2]);
	wire rd_force    = (rd_index == OFF_FORCE[7:2]);
	assign rd_mapped = rd_prescale || rd_control || rd_flag || rd_clear || rd_force;

	// Prescale word with both counts visible to software.
	wire [DATA_W-1:0] prescale_word = {20'h00000, conva_count, conva_period,
		4'h0, irq_count, irq_period};
	wire [DATA_W-1:0] control_word  = {30'h0, conva_enable, irq_enable};
	wire [DATA_W-1:0] flag_word     = {29'h0, conva_flag, 1'b0, irq_flag};

	// Clear and force registers always read as zero.
	assign rd_word = rd_prescale ? prescale_word
		: rd_control ? control_word
		: rd_flag ? flag_word
		: '0;

	// Programmed fields and enables.
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SYS_RST_IN)
		begin
			irq_period   <= PRD_RESET;
			conva_period <= PRD_RESET;
			irq_enable   <= BIT_RESET;
			conva_enable <= BIT_RESET;
		end
		else
		begin
			irq_period   <= next_irq_period;
			conva_period <= next_conva_period;
			irq_enable   <= next_irq_enable;
			conva_enable <= next_conva_enable;
		end
	end

	// Event counters and latched flags.
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SYS_RST_IN)
		begin
			irq_count   <= COUNT_RESET;
			conva_count <= COUNT_RESET;
			irq_flag    <= BIT_RESET;
			conva_flag  <= BIT_RESET;
		end
		else
		begin
			irq_count   <= next_irq_count;
			conva_count <= next_conva_count;
			irq_flag    <= next_irq_flag;
			conva_flag  <= next_conva_flag;
		end
	end

	// Output pulses. Each firing lasts one cycle because the count clears with it.
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SYS_RST_IN)
		begin
			PWM_IRQ_PULSE_OUT     <= 1'b0;
			CONVSTART_A_PULSE_OUT <= 1'b0;
		end
		else
		begin
			PWM_IRQ_PULSE_OUT     <= irq_fire;
			CONVSTART_A_PULSE_OUT <= conva_fire;
		end
	end
endmodule

// ===== etp_checker_asserts.sv
`timescale 1ns/10ps
// Port-level checks of the event prescaler and its register bus.
module etp_checker
(
	input wire logic        CLK_SYS_IN,            // System clock.
	input wire logic        SYS_RST_IN,            // Reset, active high.
	input wire logic        S_AXI_AWVALID_IN,      // Write address valid.
	input wire logic        S_AXI_AWREADY_OUT,     // Write address ready.
	input wire logic        S_AXI_WVALID_IN,       // Write data valid.
	input wire logic        S_AXI_WREADY_OUT,      // Write data ready.
	input wire logic [1:0]  S_AXI_BRESP_OUT,       // Write response.
	input wire logic        S_AXI_BVALID_OUT,      // Write response valid.
	input wire logic        S_AXI_BREADY_IN,       // Write response ready.
	input wire logic        S_AXI_ARVALID_IN,      // Read address valid.
	input wire logic        S_AXI_ARREADY_OUT,     // Read address ready.
	input wire logic [31:0] S_AXI_RDATA_OUT,       // Read data.
	input wire logic        S_AXI_RVALID_OUT,      // Read data valid.
	input wire logic        S_AXI_RREADY_IN,       // Read data ready.
	input wire logic        IRQ_EVENT_IN,          // Interrupt event.
	input wire logic        CONVA_EVENT_IN,        // Conversion A event.
	input wire logic        PWM_IRQ_PULSE_OUT,     // Interrupt pulse.
	input wire logic        CONVSTART_A_PULSE_OUT  // Conversion A pulse.
);
	logic [2:0] wage; // Cycles since the last write response.
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);
	// A pulse may follow an event or a register write, so the age of the last write is kept.
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (SYS_RST_IN)
			wage <= 3'h7;
		else if (S_AXI_BVALID_OUT)
			wage <= 3'h0;
		else if (wage != 3'h7)
			wage <= wage + 3'h1;
	end
	sequence s_wr_taken;
		S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
	endsequence
	sequence s_rd_taken;
		S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
	endsequence
	property p_irq_single;
		PWM_IRQ_PULSE_OUT |=> !PWM_IRQ_PULSE_OUT;
	endproperty
	a_irq_single: assert property (p_irq_single) else $error("irq pulse too long");
	property p_conv_single;
		CONVSTART_A_PULSE_OUT |=> !CONVSTART_A_PULSE_OUT;
	endproperty
	a_conv_single: assert property (p_conv_single) else $error("conv pulse too long");
	property p_irq_cause;
		// A forced interrupt pulses in the very cycle the write response is raised.
		PWM_IRQ_PULSE_OUT |-> $past(IRQ_EVENT_IN, 2) || S_AXI_BVALID_OUT || wage < 3'h4;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq pulse without cause");
	property p_conv_cause;
		CONVSTART_A_PULSE_OUT |-> $past(CONVA_EVENT_IN, 2) || wage < 3'h4;
	endproperty
	a_conv_cause: assert property (p_conv_cause) else $error("conv pulse without cause");
	property p_b_hold;
		S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold;
		S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_latency;
		s_wr_taken |-> ##[2:3] S_AXI_BVALID_OUT;
	endproperty
	a_b_latency: assert property (p_b_latency) else $error("write response late");
	property p_r_latency;
		s_rd_taken |-> ##[2:3] S_AXI_RVALID_OUT;
	endproperty
	a_r_latency: assert property (p_r_latency) else $error("read data late");
	property p_ar_busy;
		s_rd_taken |=> !S_AXI_ARREADY_OUT [*2];
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("second read taken");
endmodule
bind event_trigger_prescaler etp_checker u_chk (.*);

// ===== irq_adc_sink.sv
`timescale 1ns/10ps
// Far side: counts every cycle in which each pulse is high, so a long pulse counts once for each cycle it stays high.
module irq_adc_sink
(
	input  wire logic       clk_in,         // System clock.
	input  wire logic       rst_in,         // Reset, active high.
	input  wire logic       irq_in,         // Interrupt pulse.
	input  wire logic       conv_in,        // Conversion start pulse.
	output logic      [7:0] irq_count_out,  // Interrupts taken.
	output logic      [7:0] conv_count_out  // Conversions started.
);
	// The counters clear on reset and step once per high cycle.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			irq_count_out  <= 8'h00;
			conv_count_out <= 8'h00;
		end
		else
		begin
			irq_count_out  <= irq_count_out + 8'(irq_in);
			conv_count_out <= conv_count_out + 8'(conv_in);
		end
	end
endmodule

// ===== test_event_trigger_prescaler.sv
`timescale 1ns/10ps
// Bench: register bus tasks and event pulses, with pulse counts taken at the far side.
module test_event_trigger_prescaler;
	import etp_pkg::*;
	logic        clk = 1'b0;           // System clock.
	logic        rst = 1'b1;           // Reset, active high.
	logic [7:0]  awaddr = 8'h00;       // Bus signals driven by the bench.
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        irq_ev = 1'b0;        // Interrupt event input.
	logic        conv_ev = 1'b0;       // Conversion A event input.
	logic        irq_p;                // Interrupt pulse output.
	logic        conv_p;               // Conversion A pulse output.
	logic [7:0]  irq_n;                // Interrupt pulses counted.
	logic [7:0]  conv_n;               // Conversion pulses counted.
	logic [31:0] rd_val;               // Last read word.
	logic [1:0]  last_resp;            // Last bus response.
	int          mismatches = 0;
	int          num_checks = 0;
	int          ei = 0;               // Expected interrupt pulses.
	int          ec = 0;               // Expected conversion pulses.
	int          p;
	int          k;
	event_trigger_prescaler dut_u (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h3), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .IRQ_EVENT_IN(irq_ev),
		.CONVA_EVENT_IN(conv_ev), .PWM_IRQ_PULSE_OUT(irq_p), .CONVSTART_A_PULSE_OUT(conv_p));
	irq_adc_sink sink_u (.clk_in(clk), .rst_in(rst), .irq_in(irq_p), .conv_in(conv_p),
		.irq_count_out(irq_n), .conv_count_out(conv_n));
	// The clock toggles every half period of 12.5 ns.
	always #12.5 clk = ~clk;
	// Compares one value and reports a difference at once.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One write; evt raises the interrupt event in the cycle the register takes the word.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic evt = 1'b0);
		logic aw_done;
		logic w_done;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_done = 1'b0;
		w_done = 1'b0;
		// Each channel is released at the edge that takes it.
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!(aw_done && w_done));
		@(posedge clk);
		irq_ev <= evt;
		do
		begin
			@(posedge clk);
			irq_ev <= 1'b0;
		end
		while (!bvalid);
		last_resp = bresp;
		bready <= 1'b0;
	endtask
	// One read; the word lands in rd_val.
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rd_val = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_val, e);
	endtask
	// One-cycle event pulses, then time for any output pulse to pass.
	task ev(input logic i, input logic c);
		@(posedge clk);
		irq_ev <= i;
		conv_ev <= c;
		@(posedge clk);
		irq_ev <= 1'b0;
		conv_ev <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task pc();
		chk({24'h0, irq_n}, 32'(ei));
		chk({24'h0, conv_n}, 32'(ec));
	endtask
	task complete_run();
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cuts a hung run short.
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	// Main sequence.
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdc(OFF_PRESCALE, 32'h0);
		rdc(OFF_CONTROL, 32'h0);
		rdc(OFF_FLAG, 32'h0);
		rdc(8'h20, 32'h0);
		chk(32'(last_resp), 32'(RESP_SLVERR));
		wr(8'h20, 32'h1);
		chk(32'(last_resp), 32'(RESP_SLVERR));
		wr(OFF_CONTROL, 32'h3);
		// Every period on both paths; the conversion flag is left set from p = 1 on.
		for (p = 1; p < 4; p++)
		begin
			wr(OFF_PRESCALE, 32'((p << 8) | p));
			for (k = 1; k < p; k++)
			begin
				ev(1'b1, 1'b1);
				rdc(OFF_PRESCALE, 32'((k << 10) | (k << 2) | (p << 8) | p));
			end
			ev(1'b1, 1'b1);
			ei++;
			ec++;
			rdc(OFF_PRESCALE, 32'((p << 8) | p));
			rdc(OFF_FLAG, 32'h5);
			pc();
			wr(OFF_CLEAR, 32'h1);
		end
		// Flag set: the count parks and one interrupt waits for the clear.
		wr(OFF_PRESCALE, 32'h1);
		ev(1'b1, 1'b0);
		ei++;
		for (k = 0; k < 3; k++)
			ev(1'b1, 1'b0);
		rdc(OFF_PRESCALE, 32'h5);
		pc();
		wr(OFF_CLEAR, 32'h1);
		ei++;
		rdc(OFF_PRESCALE, 32'h1);
		pc();
		wr(OFF_CLEAR, 32'h1);
		// Disabled: the count parks, then the enable releases the interrupt.
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_PRESCALE, 32'h2);
		for (k = 0; k < 3; k++)
			ev(1'b1, 1'b0);
		rdc(OFF_PRESCALE, 32'ha);
		pc();
		wr(OFF_CONTROL, 32'h1);
		ei++;
		rdc(OFF_PRESCALE, 32'h2);
		pc();
		wr(OFF_CLEAR, 32'h1);
		// A period written equal to the count fires.
		wr(OFF_PRESCALE, 32'h3);
		ev(1'b1, 1'b0);
		rdc(OFF_PRESCALE, 32'h7);
		wr(OFF_PRESCALE, 32'h1);
		ei++;
		rdc(OFF_PRESCALE, 32'h1);
		pc();
		wr(OFF_CLEAR, 32'h1);
		// Period zero: nothing counts and a force is ignored.
		wr(OFF_PRESCALE, 32'h0);
		wr(OFF_CONTROL, 32'h3);
		ev(1'b1, 1'b1);
		wr(OFF_FORCE, 32'h1);
		rdc(OFF_PRESCALE, 32'h0);
		rdc(OFF_FLAG, 32'h4);
		pc();
		wr(OFF_PRESCALE, 32'h3, 1'b1);
		rdc(OFF_PRESCALE, 32'h7);
		// Conversion path disabled: the count parks until the enable.
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_PRESCALE, 32'h103);
		ev(1'b0, 1'b1);
		rdc(OFF_PRESCALE, 32'h507);
		pc();
		wr(OFF_CONTROL, 32'h3);
		ec++;
		rdc(OFF_PRESCALE, 32'h107);
		pc();
		// A force with a live period fires at once and clears the count.
		wr(OFF_FORCE, 32'h1);
		ei++;
		rdc(OFF_PRESCALE, 32'h103);
		pc();
		wr(OFF_CLEAR, 32'h5);
		rdc(OFF_FLAG, 32'h0);
		complete_run();
	end
endmodule
